//--- include/bar_cfg_pkg.sv
// Functional notes
// RL1 - endpoint offers six 32-bit windows or three 64-bit windows at most
// RL2 - root port offers two 32-bit windows or one 64-bit window at most
// RL3 - only windows 0, 2, 4 may be 64-bit; each may be 32-bit instead
// RL4 - odd window is 32-bit only; holds upper bits after 64-bit partner
// RL5 - 32-bit window size is a power of two, 4 KB up to 2 GB
// RL6 - 64-bit endpoint window spans 4 KB to 8 EB
// RL7 - all windows are memory; prefetchable set for 64-bit, clear for 32-bit
// RL8 - enabled window claims only memory requests inside its aperture
// RL9 - claimed address gets window base swapped for its AXI translation base
// RL10 - internal MSI-X reserves a 64 KB region inside one enabled window
// RL11 - selector picks window 0 to 5 for that region, internal MSI-X only
// RL12 - external MSI-X reserves nothing; surrounding logic builds the table
// RL13 - MSI on by default with one vector, up to 16, or disabled
// RL14 - one to sixteen user interrupt request inputs, count configured
// RL15 - legacy interrupt uses exactly one virtual wire, INTA to INTD
// RL16 - completion timeout defaults to 50 ms, 50 us selectable
// RL17 - timeout applies to issued memory reads still awaiting completion
// RL18 - MSI and MSI-X are mutually exclusive
// RL19 - AXI slave and master ports present by default, either removable
// RL20 - extended config interface needs outside logic to answer accesses
// RL21 - link partner transmit preset defaults to 4
// RL22 - on timeout end pending AXI read with error and flag software
package bar_cfg_pkg;
	localparam int unsigned NUM_WIN = 6;
	localparam int unsigned ADDR_W = 64;
	localparam logic [3:0] RA_CTRL = 4'h0;
	localparam logic [3:0] RA_WIN_CFG = 4'h1;
	localparam logic [3:0] RA_WIN_SEL = 4'h2;
	localparam logic [3:0] RA_BASE_LO = 4'h3;
	localparam logic [3:0] RA_BASE_HI = 4'h4;
	localparam logic [3:0] RA_XLAT_LO = 4'h5;
	localparam logic [3:0] RA_XLAT_HI = 4'h6;
	localparam logic [3:0] RA_STATUS = 4'h7;
	localparam logic [3:0] RA_INTR = 4'h8;
	localparam logic [3:0] RA_WIN_ATTR = 4'h9;
	// ctrl fields
	localparam int unsigned C_ROOT = 0;
	localparam int unsigned C_MSI_EN = 1;
	localparam int unsigned C_MSIX_EN = 2;
	localparam int unsigned C_MSIX_EXT = 3;
	localparam int unsigned C_SHORT_TO = 4;
	localparam int unsigned C_SLV_EN = 5;
	localparam int unsigned C_MST_EN = 6;
	localparam int unsigned C_EXT_CFG = 7;
	localparam logic [31:0] CTRL_RST = 32'h0000_0062;
	// win_cfg per window: [0] enable, [1] is64, [7:2] size log2
	localparam logic [7:0] WIN_CFG_RST = 8'h30;
	localparam logic [5:0] SZ_MIN = 6'h0c;
	localparam logic [5:0] SZ_MAX32 = 6'h1f;
	localparam logic [5:0] SZ_MAX64 = 6'h3f;
	localparam logic [5:0] MSIX_REGION_LOG2 = 6'h10;
	localparam logic [2:0] MSIX_SEL_RST = 3'h0;
	// intr fields: [4:0] msi vectors, [9:5] user count, [11:10] legacy wire
	localparam logic [4:0] MSI_VEC_RST = 5'h01;
	localparam logic [4:0] MSI_VEC_MAX = 5'h10;
	localparam logic [4:0] USR_CNT_RST = 5'h01;
	localparam logic [4:0] USR_CNT_MAX = 5'h10;
	localparam logic [3:0] TX_PRESET_RST = 4'h4;
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned TO_LONG_MS = 50;
	localparam int unsigned TO_SHORT_US = 50;
	localparam int unsigned TO_LONG_CYC = TO_LONG_MS * (CLK_HZ / 1000);
	localparam int unsigned TO_SHORT_CYC = TO_SHORT_US * (CLK_HZ / 1_000_000);
	localparam int unsigned TO_W = 21;
	typedef enum logic [1:0] {
		RD_IDLE = 2'b00,
		RD_WAIT = 2'b01,
		RD_DONE = 2'b11
	} rd_state_t;
	typedef enum logic [1:0] {
		INT_A = 2'h0,
		INT_B = 2'h1,
		INT_C = 2'h2,
		INT_D = 2'h3
	} legacy_wire_t;
endpackage

//--- rtl/bar_window_match.sv
`timescale 1ns/1ps
module bar_window_match import bar_cfg_pkg::*; (
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [ADDR_W-1:0] base,
	input wire logic [ADDR_W-1:0] xlat,
	input wire logic [5:0] size_log2,
	input wire logic usable,
	output logic hit,
	output logic [ADDR_W-1:0] axi_addr
);
	logic [ADDR_W-1:0] mask;
	always_comb begin
		mask = ~({ADDR_W{1'b1}} << size_log2);
		hit = usable && ((addr & ~mask) == (base & ~mask)); // RL8
		axi_addr = (xlat & ~mask) | (addr & mask); // RL9
	end
endmodule // bar_window_match

//--- rtl/cpl_timeout.sv
`timescale 1ns/1ps
module cpl_timeout import bar_cfg_pkg::*; #(
	parameter int unsigned LONG_CYC = TO_LONG_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic short_sel,
	input wire logic start,
	input wire logic stop,
	output logic expired
);
	logic [TO_W-1:0] cnt_q;
	logic run_q;
	logic [TO_W-1:0] limit;
	assign limit = short_sel ? TO_W'(TO_SHORT_CYC) : TO_W'(LONG_CYC); // RL16
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			run_q <= 1'b0;
			cnt_q <= '0;
		end else if (start) begin
			run_q <= 1'b1;
			cnt_q <= '0;
		end else if (stop || expired) begin
			run_q <= 1'b0;
		end else if (run_q) begin
			cnt_q <= cnt_q + TO_W'(1);
		end
	end
	assign expired = run_q && !stop && (cnt_q == limit - TO_W'(1)); // RL17
endmodule // cpl_timeout

//--- rtl/pcie_bar_decode.sv
`timescale 1ns/1ps
module pcie_bar_decode import bar_cfg_pkg::*; #(
	parameter int unsigned LONG_CYC = TO_LONG_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic req_valid,
	input wire logic req_is_mem,
	input wire logic req_is_read,
	input wire logic [ADDR_W-1:0] req_addr,
	output logic req_claimed,
	output logic [2:0] req_window,
	output logic req_msix_hit,
	output logic axi_valid,
	output logic [ADDR_W-1:0] axi_addr,
	output logic axi_is_read,
	input wire logic rd_cpl,
	output logic rd_err,
	output logic rd_busy,
	input wire logic [15:0] usr_irq,
	output logic [15:0] usr_irq_live,
	output logic [3:0] legacy_wire,
	output logic msi_on,
	output logic msix_on,
	output logic msix_ext_ports,
	output logic slv_port_en,
	output logic mst_port_en,
	output logic ext_cfg_fwd,
	output logic [3:0] tx_preset
);
	logic rst_m_q, rst_s_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_m_q <= 1'b0;
			rst_s_q <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_s_q <= rst_m_q;
		end
	end
	wire logic rstn = rst_s_q;
	logic [31:0] ctrl_q;
	logic [7:0] wcfg_q [NUM_WIN];
	logic [ADDR_W-1:0] base_q [NUM_WIN];
	logic [ADDR_W-1:0] xlat_q [NUM_WIN];
	logic [2:0] wsel_q;
	logic [2:0] msix_sel_q;
	logic [4:0] msi_vec_q, usr_cnt_q;
	logic [1:0] legacy_q;
	logic to_flag_q;

	// clamp a requested size into the legal range for its width
	function automatic logic [5:0] clamp_size(input logic [5:0] s, input logic is64);
		logic [5:0] hi;
		hi = is64 ? SZ_MAX64 : SZ_MAX32;
		if (s < SZ_MIN)
			clamp_size = SZ_MIN;
		else if (s > hi)
			clamp_size = hi;
		else
			clamp_size = s;
	endfunction

	function automatic logic [4:0] clamp_cnt(input logic [4:0] v, input logic [4:0] mx,
		input logic allow0);
		if (v == 5'h00 && !allow0)
			clamp_cnt = 5'h01;
		else if (v > mx)
			clamp_cnt = mx;
		else
			clamp_cnt = v;
	endfunction

	// window usability: odd windows die under a 64-bit partner, root port limits count
	logic [NUM_WIN-1:0] usable, is64;
	generate
		for (genvar i = 0; i < NUM_WIN; i++) begin : g_use
			if (i % 2 == 0) begin : g_even
				assign is64[i] = wcfg_q[i][1]; // RL3
			end else begin : g_odd
				assign is64[i] = 1'b0; // RL4
			end
			logic root_ok;
			if (i == 0) begin : g_r0
				assign root_ok = 1'b1;
			end else if (i == 1) begin : g_r1
				assign root_ok = !wcfg_q[0][1]; // RL2
			end else begin : g_rn
				assign root_ok = 1'b0; // RL2
			end
			if (i % 2 == 1) begin : g_u_odd
				assign usable[i] = wcfg_q[i][0] && !wcfg_q[i-1][1] && // RL4
					(root_ok || !ctrl_q[C_ROOT]);
			end else begin : g_u_even
				assign usable[i] = wcfg_q[i][0] && (root_ok || !ctrl_q[C_ROOT]); // RL1
			end
		end
	endgenerate

	// register writes
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= CTRL_RST; // RL13 RL19
			wsel_q <= '0;
			msix_sel_q <= MSIX_SEL_RST;
			msi_vec_q <= MSI_VEC_RST; // RL13
			usr_cnt_q <= USR_CNT_RST;
			legacy_q <= INT_A;
		end else if (reg_wr) begin
			if (reg_addr == RA_CTRL) begin
				ctrl_q <= reg_wdata;
				// msi-x request loses when msi is also asked
				ctrl_q[C_MSIX_EN] <= reg_wdata[C_MSIX_EN] && !reg_wdata[C_MSI_EN]; // RL18
			end else if (reg_addr == RA_WIN_SEL) begin
				wsel_q <= (reg_wdata[2:0] > 3'h5) ? 3'h5 : reg_wdata[2:0];
				msix_sel_q <= (reg_wdata[6:4] > 3'h5) ? 3'h5 : reg_wdata[6:4]; // RL11
			end else if (reg_addr == RA_INTR) begin
				msi_vec_q <= clamp_cnt(reg_wdata[4:0], MSI_VEC_MAX, 1'b1); // RL13
				usr_cnt_q <= clamp_cnt(reg_wdata[9:5], USR_CNT_MAX, 1'b0); // RL14
				legacy_q <= reg_wdata[11:10]; // RL15
			end
		end
	end

	generate
		for (genvar i = 0; i < NUM_WIN; i++) begin : g_win
			logic sel;
			assign sel = reg_wr && (wsel_q == 3'(i));
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					wcfg_q[i] <= WIN_CFG_RST;
					base_q[i] <= '0;
					xlat_q[i] <= '0;
				end else if (sel) begin
					if (reg_addr == RA_WIN_CFG) begin
						wcfg_q[i][0] <= reg_wdata[0];
						wcfg_q[i][1] <= (i % 2 == 0) ? reg_wdata[1] : 1'b0; // RL3 RL4
						wcfg_q[i][7:2] <= clamp_size(reg_wdata[7:2], // RL5 RL6
							(i % 2 == 0) && reg_wdata[1]);
					end else if (reg_addr == RA_BASE_LO) begin
						base_q[i][31:0] <= reg_wdata;
					end else if (reg_addr == RA_BASE_HI) begin
						base_q[i][63:32] <= reg_wdata;
					end else if (reg_addr == RA_XLAT_LO) begin
						xlat_q[i][31:0] <= reg_wdata;
					end else if (reg_addr == RA_XLAT_HI) begin
						xlat_q[i][63:32] <= reg_wdata;
					end
				end
			end
		end
	endgenerate
	// per-window address compare; 32-bit windows drop the base upper half and match only a zero request upper half
	logic [NUM_WIN-1:0] hit;
	logic [ADDR_W-1:0] xaddr [NUM_WIN];
	generate
		for (genvar i = 0; i < NUM_WIN; i++) begin : g_match
			logic [ADDR_W-1:0] eff_base;
			logic upper_ok;
			assign eff_base = is64[i] ? base_q[i] : {32'h0000_0000, base_q[i][31:0]};
			assign upper_ok = is64[i] || (req_addr[63:32] == 32'h0000_0000);
			logic raw_hit;
			bar_window_match u_m (
				.addr(req_addr),
				.base(eff_base),
				.xlat(xlat_q[i]),
				.size_log2(wcfg_q[i][7:2]),
				.usable(usable[i]),
				.hit(raw_hit),
				.axi_addr(xaddr[i])
			);
			assign hit[i] = raw_hit && upper_ok;
		end
	endgenerate

	// lowest hit wins; overlap is a software error
	logic any_hit;
	logic [2:0] hit_idx;
	always_comb begin
		any_hit = 1'b0;
		hit_idx = 3'h0;
		for (int i = NUM_WIN - 1; i >= 0; i--) begin
			if (hit[i]) begin
				any_hit = 1'b1;
				hit_idx = 3'(i);
			end
		end
	end

	logic msix_int;
	assign msix_int = ctrl_q[C_MSIX_EN] && !ctrl_q[C_MSIX_EXT]; // RL10 RL12
	logic [ADDR_W-1:0] off;
	assign off = req_addr - base_q[hit_idx];
	logic in_msix;
	assign in_msix = msix_int && (hit_idx == msix_sel_q) && // RL11
		((off >> MSIX_REGION_LOG2) == '0); // RL10
	rd_state_t st_q;
	logic timeout;
	logic take;
	assign take = req_valid && req_is_mem && any_hit && ctrl_q[C_MST_EN] && // RL8 RL19
		!(req_is_read && st_q != RD_IDLE);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			req_claimed <= 1'b0;
			req_window <= '0;
			req_msix_hit <= 1'b0;
			axi_valid <= 1'b0;
			axi_addr <= '0;
			axi_is_read <= 1'b0;
		end else begin
			req_claimed <= take;
			req_window <= hit_idx;
			req_msix_hit <= take && in_msix;
			axi_valid <= take && !in_msix;
			axi_addr <= xaddr[hit_idx]; // RL9
			axi_is_read <= req_is_read;
		end
	end

	// one outstanding read tracked against the completion timer
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= RD_IDLE;
		end else begin
			case (st_q)
				RD_IDLE: if (take && req_is_read && !in_msix) st_q <= RD_WAIT;
				RD_WAIT: if (rd_cpl || timeout) st_q <= RD_DONE;
				RD_DONE: st_q <= RD_IDLE;
				default: st_q <= RD_IDLE;
			endcase
		end
	end
	assign rd_busy = (st_q != RD_IDLE);
	cpl_timeout #(.LONG_CYC(LONG_CYC)) u_to (
		.clk(clk),
		.rst_b(rstn),
		.short_sel(ctrl_q[C_SHORT_TO]),
		.start(take && req_is_read && !in_msix && st_q == RD_IDLE),
		.stop(rd_cpl),
		.expired(timeout)
	);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rd_err <= 1'b0;
			to_flag_q <= 1'b0;
		end else begin
			rd_err <= timeout && st_q == RD_WAIT; // RL22
			// set beats a same-cycle clear
			if (timeout)
				to_flag_q <= 1'b1; // RL22
			else if (reg_wr && reg_addr == RA_STATUS && reg_wdata[0])
				to_flag_q <= 1'b0;
		end
	end

	// read path
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			if (reg_addr == RA_CTRL)
				reg_rdata <= ctrl_q;
			else if (reg_addr == RA_WIN_CFG)
				reg_rdata <= {24'h0, wcfg_q[wsel_q]};
			else if (reg_addr == RA_WIN_SEL)
				reg_rdata <= {25'h0, msix_sel_q, 1'b0, wsel_q};
			else if (reg_addr == RA_BASE_LO)
				reg_rdata <= base_q[wsel_q][31:0];
			else if (reg_addr == RA_BASE_HI)
				reg_rdata <= base_q[wsel_q][63:32];
			else if (reg_addr == RA_XLAT_LO)
				reg_rdata <= xlat_q[wsel_q][31:0];
			else if (reg_addr == RA_XLAT_HI)
				reg_rdata <= xlat_q[wsel_q][63:32];
			else if (reg_addr == RA_STATUS)
				reg_rdata <= {29'h0, st_q, to_flag_q};
			else if (reg_addr == RA_INTR)
				reg_rdata <= {20'h0, legacy_q, usr_cnt_q, msi_vec_q};
			else if (reg_addr == RA_WIN_ATTR)
				// bit0 memory space clear, bit2:1 width, bit3 prefetch
				reg_rdata <= {28'h0, is64[wsel_q], is64[wsel_q], 2'b00}; // RL7
			else
				reg_rdata <= '0;
		end else begin
			reg_rdata <= '0;
		end
	end

	// user irq inputs beyond the configured count are masked
	generate
		for (genvar i = 0; i < 16; i++) begin : g_irq
			assign usr_irq_live[i] = usr_irq[i] && (5'(i) < usr_cnt_q); // RL14
		end
	endgenerate

	assign legacy_wire = 4'h1 << legacy_q; // RL15
	assign msi_on = ctrl_q[C_MSI_EN] && msi_vec_q != 5'h00; // RL13
	assign msix_on = ctrl_q[C_MSIX_EN]; // RL18
	assign msix_ext_ports = ctrl_q[C_MSIX_EN] && ctrl_q[C_MSIX_EXT]; // RL12
	assign slv_port_en = ctrl_q[C_SLV_EN]; // RL19
	assign mst_port_en = ctrl_q[C_MST_EN]; // RL19
	assign ext_cfg_fwd = ctrl_q[C_EXT_CFG]; // RL20
	assign tx_preset = TX_PRESET_RST; // RL21

	a_msi_excl: assert property (@(posedge clk) disable iff (!rstn)
		!(msi_on && msix_on)) else $error("msi and msix both on"); // RL18
	a_claim_needs_hit: assert property (@(posedge clk) disable iff (!rstn)
		take |=> req_claimed && req_window == $past(hit_idx)) else $error("claim lost"); // RL8
	a_no_claim_miss: assert property (@(posedge clk) disable iff (!rstn)
		(req_valid && !any_hit) |=> !req_claimed) else $error("miss claimed"); // RL8
	a_odd_not64: assert property (@(posedge clk) disable iff (!rstn)
		!wcfg_q[1][1] && !wcfg_q[3][1] && !wcfg_q[5][1]) else $error("odd 64-bit"); // RL4
	a_size_range: assert property (@(posedge clk) disable iff (!rstn)
		wcfg_q[1][7:2] >= SZ_MIN && wcfg_q[1][7:2] <= SZ_MAX32) else $error("size"); // RL5
	a_timeout_err: assert property (@(posedge clk) disable iff (!rstn)
		(timeout && st_q == RD_WAIT) |=> rd_err && to_flag_q) else $error("no err"); // RL22
	a_short_to: assert property (@(posedge clk) disable iff (!rstn)
		($rose(st_q == RD_WAIT) && ctrl_q[C_SHORT_TO] && !rd_cpl)[*1] ##0
		(!rd_cpl && !reg_wr)[*8] |-> st_q == RD_WAIT) else $error("early timeout"); // RL16
	a_root_limit: assert property (@(posedge clk) disable iff (!rstn)
		ctrl_q[C_ROOT] |-> usable[5:2] == 4'h0) else $error("root windows"); // RL2
	a_prefetch: assert property (@(posedge clk) disable iff (!rstn)
		(reg_rd && reg_addr == RA_WIN_ATTR) |=> reg_rdata[3] == $past(is64[wsel_q]))
		else $error("prefetch"); // RL7
	c_read_ok: cover property (@(posedge clk) disable iff (!rstn)
		st_q == RD_WAIT ##[1:20] rd_cpl);
	c_timeout: cover property (@(posedge clk) disable iff (!rstn) rd_err);
	c_msix_hit: cover property (@(posedge clk) disable iff (!rstn) req_msix_hit);
endmodule // pcie_bar_decode

//--- sim/link_partner_model.sv
`timescale 1ns/1ps
module link_partner_model import bar_cfg_pkg::*; (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic axi_valid,
	input wire logic axi_is_read,
	input wire logic cpl_en,
	input wire logic [7:0] cpl_dly,
	output logic req_valid,
	output logic req_is_mem,
	output logic req_is_read,
	output logic [ADDR_W-1:0] req_addr,
	output logic rd_cpl
);
	logic pend;
	logic [7:0] cnt;
	initial begin
		req_valid = 1'b0;
		req_is_mem = 1'b0;
		req_is_read = 1'b0;
		req_addr = '0;
	end
	task automatic send(input logic m, input logic r, input logic [ADDR_W-1:0] a);
		@(posedge clk);
		req_valid <= 1'b1;
		req_is_mem <= m;
		req_is_read <= r;
		req_addr <= a;
		@(posedge clk);
		req_valid <= 1'b0;
		// released lines carry junk, never the last value
		req_is_mem <= ~m;
		req_is_read <= ~r;
		req_addr <= ~a;
	endtask
	// completions prompt or slow; withheld entirely to provoke a timeout
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_cpl <= 1'b0;
			pend <= 1'b0;
			cnt <= 8'h00;
		end else begin
			rd_cpl <= 1'b0;
			if (axi_valid && axi_is_read && cpl_en) begin
				pend <= 1'b1;
				cnt <= cpl_dly;
			end else if (pend) begin
				if (cnt == 8'h00) begin
					rd_cpl <= 1'b1;
					pend <= 1'b0;
				end else begin
					cnt <= cnt - 8'h01;
				end
			end
		end
	end
endmodule // link_partner_model

//--- sim/tb_pcie_bar_decode.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
	$display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb_pcie_bar_decode import bar_cfg_pkg::*;;
	localparam int LONG = 200;
	int error_cnt = 0;
	int comparisons = 0;
	int n;
	int hits;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] usr_irq = 16'h0;
	logic cpl_en = 1'b1;
	logic [7:0] cpl_dly = 8'h03;
	logic [31:0] rd_v;
	logic c_claim, c_vld, c_msix, c_isrd;
	logic [2:0] c_win;
	logic [63:0] c_axi;
	wire logic [31:0] reg_rdata;
	wire logic req_valid, req_is_mem, req_is_read, req_claimed, req_msix_hit, axi_valid, axi_is_read;
	wire logic rd_cpl, rd_err, rd_busy, msi_on, msix_on, msix_ext_ports, slv_port_en, mst_port_en;
	wire logic ext_cfg_fwd;
	wire logic [63:0] req_addr, axi_addr;
	wire logic [2:0] req_window;
	wire logic [15:0] usr_irq_live;
	wire logic [3:0] legacy_wire, tx_preset;
	always #12.5 clk = ~clk;
	pcie_bar_decode #(.LONG_CYC(LONG)) u_pcie_bar_decode (.clk(clk), .rst_b(rst_b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .req_valid(req_valid), .req_is_mem(req_is_mem),
		.req_is_read(req_is_read), .req_addr(req_addr), .req_claimed(req_claimed),
		.req_window(req_window), .req_msix_hit(req_msix_hit), .axi_valid(axi_valid),
		.axi_addr(axi_addr), .axi_is_read(axi_is_read), .rd_cpl(rd_cpl), .rd_err(rd_err),
		.rd_busy(rd_busy), .usr_irq(usr_irq), .usr_irq_live(usr_irq_live),
		.legacy_wire(legacy_wire), .msi_on(msi_on), .msix_on(msix_on),
		.msix_ext_ports(msix_ext_ports), .slv_port_en(slv_port_en), .mst_port_en(mst_port_en),
		.ext_cfg_fwd(ext_cfg_fwd), .tx_preset(tx_preset));
	link_partner_model u_link_partner_model (.clk(clk), .rst_b(rst_b), .axi_valid(axi_valid),
		.axi_is_read(axi_is_read), .cpl_en(cpl_en), .cpl_dly(cpl_dly), .req_valid(req_valid),
		.req_is_mem(req_is_mem), .req_is_read(req_is_read), .req_addr(req_addr),
		.rd_cpl(rd_cpl));
	task automatic close_out;
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		// register updates land in this edge's nba region; look after it
		@(negedge clk);
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		rd_v = reg_rdata;
	endtask
	task automatic win(input logic [31:0] sel, input logic [31:0] cfg, input logic [63:0] b,
		input logic [63:0] x);
		wr(RA_WIN_SEL, sel);
		wr(RA_WIN_CFG, cfg);
		wr(RA_BASE_LO, b[31:0]);
		wr(RA_BASE_HI, b[63:32]);
		wr(RA_XLAT_LO, x[31:0]);
		wr(RA_XLAT_HI, x[63:32]);
	endtask
	task automatic req(input logic m, input logic r, input logic [63:0] a);
		u_link_partner_model.send(m, r, a);
		@(negedge clk);
		c_claim = req_claimed;
		c_win = req_window;
		c_axi = axi_addr;
		c_vld = axi_valid;
		c_msix = req_msix_hit;
		c_isrd = axi_is_read;
	endtask
	task automatic wait_err;
		n = 0;
		while (rd_err !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
	endtask
	// one probe per 64 KB step of a 1 MB window
	task automatic msix_scan;
		hits = 0;
		for (int k = 0; k < 16; k++) begin
			req(1'b1, 1'b0, 64'h3000_0000 + 64'(k) * 64'h1_0000);
			if (c_msix === 1'b1) hits++;
		end
	endtask
	initial begin
		repeat (30000) @(posedge clk);
		error_cnt++;
		close_out;
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		rd(RA_CTRL);
		`CHK("ctrl_rst", 32'h0000_0062, rd_v)
		rd(RA_INTR);
		`CHK("intr_rst", 32'h0000_0021, rd_v)
		`CHK("preset", 4'h4, tx_preset)
		rd(4'hf);
		`CHK("unmapped", 32'h0, rd_v)
		win(32'h0, 32'h31, 64'h1000_0000, 64'h4_0000);
		req(1'b1, 1'b0, 64'h1000_0123);
		`CHK("claim_in", 1'b1, c_claim)
		`CHK("axi_addr32", 64'h4_0123, c_axi)
		`CHK("axi_vld", 1'b1, c_vld)
		req(1'b1, 1'b0, 64'h1000_1000);
		`CHK("claim_edge", 1'b0, c_claim)
		req(1'b0, 1'b0, 64'h1000_0010);
		`CHK("claim_io", 1'b0, c_claim)
		rd(RA_WIN_ATTR);
		`CHK("attr32", 32'h0, rd_v)
		wr(RA_WIN_SEL, 32'h2);
		wr(RA_WIN_CFG, 32'ha1);
		rd(RA_WIN_CFG);
		`CHK("size_max", 32'h7d, rd_v)
		wr(RA_WIN_CFG, 32'h15);
		rd(RA_WIN_CFG);
		`CHK("size_min", 32'h31, rd_v)
		wr(RA_WIN_SEL, 32'h3);
		wr(RA_WIN_CFG, 32'h33);
		rd(RA_WIN_CFG);
		`CHK("odd_64", 32'h31, rd_v)
		wr(RA_WIN_CFG, 32'h30);
		win(32'h0, 32'h83, 64'h10_0000_0000, 64'h20_0000_0000);
		rd(RA_WIN_CFG);
		`CHK("cfg64", 32'h83, rd_v)
		rd(RA_WIN_ATTR);
		`CHK("attr64", 32'hc, rd_v)
		win(32'h1, 32'h31, 64'h2000_0000, 64'h0);
		req(1'b1, 1'b0, 64'h2000_0010);
		`CHK("upper_half", 1'b0, c_claim)
		req(1'b1, 1'b0, 64'h10_ffff_fff0);
		`CHK("axi_addr64", 64'h20_ffff_fff0, c_axi)
		`CHK("win64", 3'h0, c_win)
		req(1'b1, 1'b0, 64'h11_0000_0000);
		`CHK("edge64", 1'b0, c_claim)
		req(1'b1, 1'b1, 64'h10_0000_0040);
		`CHK("rd_isrd", 1'b1, c_isrd)
		hits = 0;
		repeat (LONG + 20) begin
			@(negedge clk);
			if (rd_err === 1'b1) hits++;
		end
		`CHK("cpl_ok", 0, hits)
		`CHK("idle", 1'b0, rd_busy)
		cpl_en <= 1'b0;
		req(1'b1, 1'b1, 64'h10_0000_0080);
		wait_err;
		`CHK("to_long", 1'b1, n >= LONG - 2 && n <= LONG + 2)
		rd(RA_STATUS);
		`CHK("to_flag", 32'h1, rd_v)
		wr(RA_STATUS, 32'h1);
		rd(RA_STATUS);
		`CHK("to_clr", 32'h0, rd_v)
		wr(RA_CTRL, 32'h72);
		req(1'b1, 1'b1, 64'h10_0000_0080);
		req(1'b1, 1'b1, 64'h10_0000_00c0);
		`CHK("busy_refuse", 1'b0, c_claim)
		wait_err;
		`CHK("to_short", 1'b1, n >= TO_SHORT_CYC - 5 && n <= TO_SHORT_CYC + 2)
		cpl_en <= 1'b1;
		wr(RA_CTRL, 32'h66);
		`CHK("msi_excl", 2'b10, {msi_on, msix_on})
		wr(RA_CTRL, 32'h64);
		`CHK("msix_only", 2'b01, {msi_on, msix_on})
		win(32'h0, 32'h51, 64'h3000_0000, 64'h0);
		msix_scan;
		`CHK("msix_int", 1, hits)
		wr(RA_CTRL, 32'h6c);
		`CHK("msix_ext", 1'b1, msix_ext_ports)
		msix_scan;
		`CHK("msix_none", 0, hits)
		wr(RA_CTRL, 32'h22);
		`CHK("ports", 2'b10, {slv_port_en, mst_port_en})
		req(1'b1, 1'b0, 64'h3000_0010);
		`CHK("mst_off", 1'b0, c_claim)
		wr(RA_CTRL, 32'he2);
		`CHK("ext_cfg", 1'b1, ext_cfg_fwd)
		win(32'h2, 32'h31, 64'h5000_0000, 64'h0);
		wr(RA_CTRL, 32'h63);
		req(1'b1, 1'b0, 64'h5000_0010);
		`CHK("root_w2", 1'b0, c_claim)
		wr(RA_CTRL, 32'h62);
		req(1'b1, 1'b0, 64'h5000_0010);
		`CHK("ep_w2", 3'h2, c_win)
		@(posedge clk);
		usr_irq <= 16'hffff;
		for (int w = 0; w < 4; w++) begin
			wr(RA_INTR, (32'(w) << 10) | 32'h21f);
			`CHK("legacy", 4'h1 << w, legacy_wire)
			rd(RA_INTR);
			`CHK("intr_clamp", (32'(w) << 10) | 32'h210, rd_v)
		end
		`CHK("usr_all", 16'hffff, usr_irq_live)
		wr(RA_INTR, 32'h60);
		`CHK("usr_three", 16'h0007, usr_irq_live)
		close_out;
	end
endmodule // tb_pcie_bar_decode
